/* File: core/io_byte_lane_steering.sv */
// Byte-lane steering between processor load/store path, controller
// registers and the expansion bus, plus the DMA byte path.
// Assumes one 50 MHz clock; the bus side answers with a done pulse.
//
// Overview of operation
// [R1] Big-endian mode: one-word store keeps register byte 0 on target byte 0.
// [R2] Little-endian mode: leftmost register byte lands on target byte 3.
// [R3] With true-little-endian processor, little-endian routing equals big.
// [R4] Bytes move whole; bit order inside every byte is kept.
// [R5] Controller registers get the same lane steering as bus regs in every mode.
// [R6] Word access to halfword bus device (not controller regs) splits into two bus cycles.
// [R7] Slave DMA and bus-master DMA share one identical data path.
// [R8] DMA moves bytes as a plain stream, byte 0 first, no reordering.
// [R9] Little-endian mode assumes a little-endian target and steers so.
// [R10] Table-entry fetches use the same untranslated DMA byte path.
// [R11] Byte and halfword accesses follow the word mapping on their lanes.
`timescale 1ns/10ps
`include "lane_steer_map.svh"
module io_byte_lane_steering
  import lane_steer_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        BYTE_ORDER_MODE_IN,
  input  wire logic        TRUE_LITTLE_ENDIAN_IMPL_IN,
  input  wire logic        REQ_VALID_IN,
  input  wire pio_req_t    REQ_IN,
  output logic             REQ_READY_OUT,
  output logic             RESP_VALID_OUT,
  output logic [31:0]      RESP_DATA_OUT,
  output logic             CYC_VALID_OUT,
  output bus_cyc_t         CYC_OUT,
  input  wire logic        CYC_DONE_IN,
  input  wire logic [31:0] CYC_RDATA_IN,
  input  wire logic        DMA_SLAVE_VALID_IN,
  input  wire logic        DMA_MASTER_VALID_IN,
  input  wire logic [31:0] DMA_DATA_IN,
  output logic             DMA_READY_OUT,
  output logic             DMA_VALID_OUT,
  output logic [31:0]      DMA_DATA_OUT,
  input  wire logic        DMA_READY_IN
);
  pio_regs_t r;
  pio_regs_t next_r;
  logic      mode_meta;
  logic      mode_sync;
  logic      self_steer_meta;
  logic      self_steer_sync;

  // Register word with its bytes reversed, for the lane checks below
  logic [31:0] req_rev;

  // Reverse byte order within a lane group; bits inside a byte kept
  function automatic logic [31:0] swap_bytes(input logic [31:0] d,
                                             input logic [1:0]  sz);
    case (sz)
      `SIZE_WORD: swap_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
      `SIZE_HALF: swap_bytes = {16'h0000, d[7:0], d[15:8]};
      default:    swap_bytes = {24'h000000, d[7:0]};
    endcase
  endfunction

  // Register byte 0 reaches bus byte 0 by crossing the lanes, except in
  // little-endian mode without a self-steering processor, where the
  // target is taken as little-endian and lanes stay put
  function automatic logic need_swap(input logic mode,
                                     input logic self_steer);
    need_swap = !((mode == `MODE_LITTLE_END) &&
                  !self_steer);             // see [R3] see [R9]
  endfunction

  // Lane enables of a request of the given size at the given address
  function automatic logic [3:0] lane_mask(input logic [1:0] sz,
                                           input logic [1:0] a);
    case (sz)
      `SIZE_WORD: lane_mask = 4'hF;
      `SIZE_HALF: lane_mask = a[1] ? 4'hC : 4'h3;
      default:    lane_mask = 4'(4'h1 << a);
    endcase
  endfunction

  // Move low-aligned byte or halfword data onto the lanes it addresses
  function automatic logic [31:0] to_lanes(input logic [31:0] d,
                                           input logic [1:0]  sz,
                                           input logic [1:0]  a);
    case (sz)
      `SIZE_WORD: to_lanes = d;
      `SIZE_HALF: to_lanes = a[1] ? {d[15:0], 16'h0000} :
                                    {16'h0000, d[15:0]};
      default:    to_lanes = {24'h000000, d[7:0]} << {a, 3'h0};
    endcase
  endfunction

  // Bring byte or halfword read data down from its lanes
  function automatic logic [31:0] from_lanes(input logic [31:0] d,
                                             input logic [1:0]  sz,
                                             input logic [1:0]  a);
    case (sz)
      `SIZE_WORD: from_lanes = d;
      `SIZE_HALF: from_lanes = {16'h0000, a[1] ? d[31:16] : d[15:0]};
      default:    from_lanes = {24'h000000, 8'(d >> {a, 3'h0})};
    endcase
  endfunction

  // Mode and implementation straps are pins: two flip-flops each
  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      self_steer_meta <= 1'b0;
      self_steer_sync <= 1'b0;
    end else begin
      mode_meta <= BYTE_ORDER_MODE_IN;
      mode_sync <= mode_meta;
      self_steer_meta <= TRUE_LITTLE_ENDIAN_IMPL_IN;
      self_steer_sync <= self_steer_meta;
    end
  end

  assign REQ_READY_OUT  = (r.state == IDLE);
  assign CYC_VALID_OUT  = r.cyc_valid;
  assign CYC_OUT        = r.cyc;
  assign RESP_VALID_OUT = r.rdone;
  assign RESP_DATA_OUT  = r.rdata;

  // Request sequencing, lane steering and bus sizing
  always_comb begin
    logic [31:0] sd;
    logic        sw;
    logic [1:0]  sz;
    logic [31:0] rd;
    sd = '0;
    sw = 1'b0;
    sz = r.req.size;
    rd = '0;
    next_r       = r;
    next_r.mode  = mode_sync;
    next_r.self_steer = self_steer_sync;
    next_r.rdone = 1'b0;
    sw = need_swap(r.mode, r.self_steer);   // see [R5] one rule for all
    case (r.state)
      IDLE: begin
        if (REQ_VALID_IN) begin
          next_r.req   = REQ_IN;
          next_r.state = FIRST;
        end
      end
      FIRST: begin
        // Whole bytes swapped, never bits        see [R1] see [R2] see [R4]
        sd = sw ? swap_bytes(r.req.data, sz) : r.req.data;
        sd = to_lanes(sd, sz, r.req.addr_lo);       // see [R11]
        next_r.cyc.store    = r.req.store;
        next_r.cyc.internal = r.req.internal;
        next_r.cyc.addr_lo  = r.req.addr_lo;
        next_r.cyc.lanes    = lane_mask(sz, r.req.addr_lo); // see [R11]
        next_r.cyc.data     = sd;
        if (sz == `SIZE_WORD && r.req.width == `BUS_WIDTH_HALF &&
            !r.req.internal) begin
          // First half of a split word        see [R6]
          next_r.cyc.lanes = 4'h3;
          next_r.cyc.data  = {16'h0000, sd[15:0]};
          next_r.low_half  = sd[31:16];
        end
        next_r.cyc_valid = 1'b1;
        next_r.state     = SECOND;
      end
      SECOND: begin
        if (CYC_DONE_IN) begin
          next_r.cyc_valid = 1'b0;
          if (next_r.cyc.lanes == 4'h3 && sz == `SIZE_WORD &&
              r.req.width == `BUS_WIDTH_HALF && !r.req.internal &&
              r.cyc.addr_lo == r.req.addr_lo) begin
            // Second half on the next address       see [R6]
            next_r.rdata[15:0] = CYC_RDATA_IN[15:0];
            next_r.cyc.addr_lo = r.req.addr_lo + 2'h2;
            next_r.cyc.data    = {16'h0000, r.low_half};
            next_r.cyc_valid   = 1'b1;
          end else begin
            rd = (sz == `SIZE_WORD && r.req.width == `BUS_WIDTH_HALF &&
                  !r.req.internal) ?
                 {CYC_RDATA_IN[15:0], r.rdata[15:0]} : CYC_RDATA_IN;
            rd = from_lanes(rd, sz, r.req.addr_lo);  // see [R11]
            next_r.rdata = sw ? swap_bytes(rd, sz) : rd; // see [R9]
            next_r.state = DONE;
          end
        end
      end
      DONE: begin
        next_r.rdone = !r.req.store;
        next_r.state = IDLE;
      end
      default: next_r.state = IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!NRST_IN)
      r <= '0;
    else
      r <= next_r;
  end

  // Both DMA kinds merged onto one untouched path         see [R7]
  dma_byte_path u_dma (
    .clk_in        (CLOCK_IN),
    .nrst_in       (NRST_IN),
    .in_valid_in   (DMA_SLAVE_VALID_IN || DMA_MASTER_VALID_IN),
    .in_data_in    (DMA_DATA_IN),
    .in_ready_out  (DMA_READY_OUT),
    .out_valid_out (DMA_VALID_OUT),
    .out_data_out  (DMA_DATA_OUT),
    .out_ready_in  (DMA_READY_IN)
  );

  // Byte 0 of the register is [31:24]; bus byte n is data[8n+7:8n]
  assign req_rev = {r.req.data[7:0], r.req.data[15:8],
                    r.req.data[23:16], r.req.data[31:24]};

  be_word_a: assert property ( // see [R1]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    r.state == FIRST && r.mode == `MODE_BIG_ENDIAN &&
    r.req.size == `SIZE_WORD && r.req.width == `BUS_WIDTH_WORD
    |=> CYC_OUT.data == $past(req_rev))
    else $error("big-endian word lanes moved");
  little_word_a: assert property ( // see [R2]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    r.state == FIRST && r.mode == `MODE_LITTLE_END && !r.self_steer &&
    r.req.size == `SIZE_WORD && r.req.width == `BUS_WIDTH_WORD
    |=> CYC_OUT.data[31:24] == $past(r.req.data[31:24]))
    else $error("leftmost byte not on lane 3");
  self_steer_same_a: assert property ( // see [R3]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    r.state == FIRST && r.self_steer && r.req.size == `SIZE_WORD &&
    r.req.width == `BUS_WIDTH_WORD
    |=> CYC_OUT.data == $past(req_rev))
    else $error("self-steering routing differs from big-endian");
  split_word_a: assert property ( // see [R6]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    r.state == FIRST && r.req.size == `SIZE_WORD &&
    r.req.width == `BUS_WIDTH_HALF && !r.req.internal
    |=> CYC_VALID_OUT && CYC_OUT.lanes == 4'h3)
    else $error("word to halfword not split");
  byte_lane_a: assert property ( // see [R11]
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    r.state == FIRST && r.req.size == `SIZE_BYTE
    |=> CYC_OUT.lanes == 4'(4'h1 << $past(r.req.addr_lo)))
    else $error("byte lane wrong");
  c_little_store: cover property (@(posedge CLOCK_IN)
    r.state == FIRST && r.mode == `MODE_LITTLE_END && r.req.store);
  c_split: cover property (@(posedge CLOCK_IN)
    r.state == SECOND && CYC_DONE_IN && r.cyc.addr_lo != r.req.addr_lo);
  c_load: cover property (@(posedge CLOCK_IN) RESP_VALID_OUT);
  c_dma: cover property (@(posedge CLOCK_IN)
    DMA_VALID_OUT && !DMA_READY_IN);
endmodule

/* File: core/lane_steer_map.svh */
// Constants for the byte-lane steering block: widths, sizes and byte-order modes.
// Assumes inclusion by the package and the design files only.
`ifndef LANE_STEER_MAP_SVH
`define LANE_STEER_MAP_SVH
`define LANE_BYTES        4
`define WORD_BITS         32
`define HALF_BITS         16
`define SIZE_BYTE         2'h0
`define SIZE_HALF         2'h1
`define SIZE_WORD         2'h2
`define BUS_WIDTH_BYTE    2'h0
`define BUS_WIDTH_HALF    2'h1
`define BUS_WIDTH_WORD    2'h2
`define MODE_BIG_ENDIAN   1'h0
`define MODE_LITTLE_END   1'h1
`endif

/* File: core/lane_steer_pkg.sv */
// Types shared by the byte-lane steering block.
// Assumes lane_steer_map.svh is on the include path.
`include "lane_steer_map.svh"
package lane_steer_pkg;
  // One load or store request from the processor path
  typedef struct packed {
    logic        store;
    logic        internal;
    logic [1:0]  size;
    logic [1:0]  width;
    logic [1:0]  addr_lo;
    logic [31:0] data;
  } pio_req_t;

  // One bus cycle as driven toward the expansion bus or controller regs
  typedef struct packed {
    logic        store;
    logic        internal;
    logic [3:0]  lanes;
    logic [1:0]  addr_lo;
    logic [31:0] data;
  } bus_cyc_t;

  typedef enum logic [1:0] {IDLE, FIRST, SECOND, DONE} pio_state_t;

  typedef struct packed {
    pio_state_t  state;
    logic        mode;
    logic        self_steer;
    pio_req_t    req;
    bus_cyc_t    cyc;
    logic        cyc_valid;
    logic [15:0] low_half;
    logic [31:0] rdata;
    logic        rdone;
  } pio_regs_t;

  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } dma_regs_t;
endpackage

/* File: core/dma_byte_path.sv */
// DMA byte path: moves memory words to and from the bus unchanged.
// Assumes one clock; both sides use valid/ready on the same clock.
`timescale 1ns/10ps
module dma_byte_path
  import lane_steer_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        in_valid_in,
  input  wire logic [31:0] in_data_in,
  output logic             in_ready_out,
  output logic             out_valid_out,
  output logic [31:0]      out_data_out,
  input  wire logic        out_ready_in
);
  dma_regs_t r;
  dma_regs_t next_r;

  assign in_ready_out  = !r.valid || out_ready_in;
  assign out_valid_out = r.valid;
  assign out_data_out  = r.data;

  // One stage; byte 0 stays byte 0, no swap for any mode or table fetch
  always_comb begin
    next_r = r;
    if (out_ready_in)
      next_r.valid = 1'b0;
    if (in_valid_in && in_ready_out) begin
      next_r.valid = 1'b1;
      next_r.data  = in_data_in;            // see [R8] see [R10]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in)
      r <= '0;
    else
      r <= next_r;
  end

  data_unchanged_a: assert property ( // see [R8]
    @(posedge clk_in) disable iff (!nrst_in)
    in_valid_in && in_ready_out |=> out_valid_out &&
    out_data_out == $past(in_data_in))
    else $error("dma byte order changed");
  hold_stall_a: assert property ( // see [R10]
    @(posedge clk_in) disable iff (!nrst_in)
    out_valid_out && !out_ready_in |=> out_valid_out &&
    $stable(out_data_out))
    else $error("dma data dropped under stall");
endmodule

/* File: tb/bus_target_model.sv */
// Bus target model: answers each bus cycle with a one-cycle done pulse.
// Assumes the block holds its cycle until it has seen done.
`timescale 1ns/10ps
module bus_target_model
  import lane_steer_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        cyc_valid_in,
  input  wire bus_cyc_t    cyc_in,
  input  wire logic [3:0]  wait_in,
  input  wire logic [31:0] rd_word_in,
  output logic             done_out,
  output logic [31:0]      rdata_out,
  output bus_cyc_t         older_out,
  output bus_cyc_t         latest_out,
  output logic [7:0]       count_out
);
  logic [3:0] waited;

  // Read data is valid only with done; otherwise show the inverse
  assign rdata_out = done_out ? rd_word_in : ~rd_word_in;

  // Wait states, then pulse done and record the cycle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      done_out <= 1'b0;
      waited <= 4'h0;
      count_out <= 8'h0;
      older_out <= '0;
      latest_out <= '0;
    end else if (done_out) begin
      done_out <= 1'b0;
      waited <= 4'h0;
    end else if (cyc_valid_in) begin
      if (waited == wait_in) begin
        done_out <= 1'b1;
        older_out <= latest_out;
        latest_out <= cyc_in;
        count_out <= count_out + 8'h1;
      end else begin
        waited <= waited + 4'h1;
      end
    end
  end
endmodule

/* File: tb/test_io_byte_lane_steering.sv */
// Self-checking bench for the byte-lane steering block.
// Assumes the core package and the bus target model are compiled first.
`timescale 1ns/10ps
module test_io_byte_lane_steering
  import lane_steer_pkg::*;
;
  logic clk = 0, nrst = 0, mode = 0, self_steer = 0, rv = 0, sv = 0;
  logic mv = 0;
  logic dr = 0, rr, rsp_v, cv, done, dv, drdy;
  logic [3:0] wt = 4'h0;
  logic [31:0] dd = 0, rw = 32'hA1B2C3D4, rsp, crd, dout, got;
  pio_req_t req = '0;
  bus_cyc_t cyc, sa, sb;
  logic [7:0] cnt;
  int bad_count = 0, checks_done = 0;

  io_byte_lane_steering dut_u (.CLOCK_IN(clk), .NRST_IN(nrst),
    .BYTE_ORDER_MODE_IN(mode), .TRUE_LITTLE_ENDIAN_IMPL_IN(self_steer),
    .REQ_VALID_IN(rv), .REQ_IN(req), .REQ_READY_OUT(rr),
    .RESP_VALID_OUT(rsp_v), .RESP_DATA_OUT(rsp), .CYC_VALID_OUT(cv),
    .CYC_OUT(cyc), .CYC_DONE_IN(done), .CYC_RDATA_IN(crd),
    .DMA_SLAVE_VALID_IN(sv), .DMA_MASTER_VALID_IN(mv),
    .DMA_DATA_IN(dd), .DMA_READY_OUT(drdy), .DMA_VALID_OUT(dv),
    .DMA_DATA_OUT(dout), .DMA_READY_IN(dr));
  bus_target_model tgt_u (.clk_in(clk), .nrst_in(nrst),
    .cyc_valid_in(cv), .cyc_in(cyc), .wait_in(wt), .rd_word_in(rw),
    .done_out(done), .rdata_out(crd), .older_out(sa),
    .latest_out(sb), .count_out(cnt));

  initial forever #10 clk = ~clk;

  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rev(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // One load or store; waits for n bus cycles and, on loads, the answer
  task automatic pio(input logic st, it, input logic [1:0] sz, wd, al,
                     input logic [31:0] d, input logic [7:0] n);
    logic [7:0] c0;
    int k;
    c0 = cnt;
    k = 0;
    while (rr !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    req = '{st, it, sz, wd, al, d};
    rv = 1;
    tick(1);
    rv = 0;
    while ((8'(cnt - c0) != n || (!st && rsp_v !== 1'b1)) && k < 200) begin
      tick(1);
      k++;
    end
    check(32'(k < 200), 32'h1);
    got = rsp;
    tick(3);
  endtask

  // Word stores to bus and controller regs, and a load, per mode setting
  task automatic t_word();
    logic [31:0] e;
    for (int m = 0; m < 3; m++) begin
      mode = (m != 0);
      self_steer = (m == 2);
      tick(6);
      e = (m == 1) ? 32'h11121314 : rev(32'h11121314);
      for (int i = 0; i < 2; i++) begin
        pio(1, i[0], 2'h2, 2'h2, 2'h0, 32'h11121314, 1);
        check(sb.data, e);
        check(32'(sb.lanes), 32'hF);
      end
      pio(0, 0, 2'h2, 2'h2, 2'h0, 0, 1);
      check(got, (m == 1) ? rw : rev(rw));
    end
  endtask

  // Halfword and byte stores on narrow devices, both modes
  task automatic t_narrow();
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      self_steer = 0;
      tick(6);
      pio(1, 0, 2'h1, 2'h1, 2'h0, 32'h81C2, 1);
      check({sb.data[15:0], 12'h0, sb.lanes},
            {m ? 16'h81C2 : 16'hC281, 16'h3});
      pio(1, 0, 2'h0, 2'h0, 2'h1, 32'h81, 1);
      check({sb.data[15:8], 20'h0, sb.lanes}, 32'h81000002);
    end
  endtask

  // Word store and load to a halfword device with a slow target
  task automatic t_split();
    mode = 0;
    wt = 4'h5;
    tick(6);
    pio(1, 0, 2'h2, 2'h1, 2'h0, 32'h11121314, 2);
    check({sa.data[15:0], sb.data[15:0]}, 32'h12111413);
    check({28'h0, sa.addr_lo, sb.addr_lo}, 32'h2);
    // Each half reads the low bus half; halves join, then lanes cross
    pio(0, 0, 2'h2, 2'h1, 2'h0, 0, 2);
    check(got, rev({rw[15:0], rw[15:0]}));
    wt = 4'h0;
  endtask

  // Slave and master words alternate; sink stalls at first
  task automatic t_dma();
    logic [31:0] w [4];
    int k, q;
    w = '{32'h11121314, 32'h21222324, 32'h31323334, 32'h41424344};
    fork
      begin
        for (int i = 0; i < 4; i++) begin
          dd = w[i];
          sv = !i[0];
          mv = i[0];
          k = 0;
          // The word goes in at the edge where ready is seen high
          do begin
            @(posedge clk);
            k++;
          end while (drdy !== 1'b1 && k < 50);
          #2;
        end
        sv = 0;
        mv = 0;
      end
      begin
        tick(5);
        dr = 1;
        for (int j = 0; j < 4; j++) begin
          q = 0;
          while (dv !== 1'b1 && q < 50) begin
            tick(1);
            q++;
          end
          check(dout, w[j]);
          tick(1);
        end
      end
    join
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence after a 12-cycle reset
  initial begin
    tick(12);
    nrst = 1;
    tick(2);
    t_word();
    t_narrow();
    t_split();
    t_dma();
    stop_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
endmodule
